// file: pkg/pwrseq_pkg.sv
/*
 * Constants for the push button power sequencer: timing figures and their cycle counts.
 * Assumes a 100 MHz sys_clk.
 */
package pwrseq_pkg;
   // ****************************************
   // Clock and time figures
   // ****************************************
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned DEBOUNCE_MS = 32;
   localparam int unsigned ON_BLANK_MS = 512;
   localparam int unsigned OFF_DELAY_MS = 1024;
   localparam int unsigned LOCKOUT_MS = 256;
   localparam int unsigned RELEASE_MS = 32;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned ON_BLANK_CYC = ON_BLANK_MS * CYC_PER_MS;
   localparam int unsigned OFF_DELAY_CYC = OFF_DELAY_MS * CYC_PER_MS;
   localparam int unsigned LOCKOUT_CYC = LOCKOUT_MS * CYC_PER_MS;
   localparam int unsigned RELEASE_CYC = RELEASE_MS * CYC_PER_MS;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned EXT_W = 32;
endpackage : pwrseq_pkg

// file: pkg/timer_if.sv
/*
 * Interface between the sequencer and its interval timer.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface timer_if;
   logic start;
   logic [pwrseq_pkg::CNT_W-1:0] length;
   logic done;
   modport ctrl (output start, output length, input done);
   modport tmr (input start, input length, output done);
endinterface : timer_if

// file: hw/interval_timer.sv
/*
 * Down counter: start loads a length, done pulses one cycle when it expires.
 * Assumes synchronous reset and a clock enable that freezes it.
 */
`timescale 1ns/1ps
module interval_timer (
   input wire logic sys_clk, // Clock
   input wire logic reset, // Synchronous reset
   input wire logic clk_en, // Freezes state when low
   timer_if.tmr tif // Start, length and done
);
   typedef struct packed {
      logic [pwrseq_pkg::CNT_W-1:0] count;
      logic running;
      logic done;
   } tmr_state_t;
   tmr_state_t state_reg;
   tmr_state_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      if (tif.start) begin
         // Length of at least one cycle so done is never lost
         state_next.count = (tif.length > 32'h1) ? tif.length - 32'h1 : 32'h0;
         state_next.running = 1'b1;
      end else if (state_reg.running) begin
         if (state_reg.count == 32'h0) begin
            state_next.running = 1'b0;
            state_next.done = 1'b1;
         end else begin
            state_next.count = state_reg.count - 32'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign tif.done = state_reg.done;
endmodule : interval_timer

// file: hw/pushbutton_power_sequencer.sv
/*
 * Push button power sequencer: debounced on/off presses toggle a power enable,
 * with a processor shutdown request and power-off request handshake.
 * Assumes all inputs synchronous to sys_clk; extensions are cycle counts held stable.
 */
`timescale 1ns/1ps
module pushbutton_power_sequencer #(
   parameter bit ENABLE_ACTIVE_HIGH = 1'b1, // Variant polarity of the enable
   parameter int unsigned DEBOUNCE_CYC = pwrseq_pkg::DEBOUNCE_CYC, // Press debounce
   parameter int unsigned ON_BLANK_CYC = pwrseq_pkg::ON_BLANK_CYC, // Turn-on blanking
   parameter int unsigned OFF_DELAY_CYC = pwrseq_pkg::OFF_DELAY_CYC, // Turn-off delay
   parameter int unsigned LOCKOUT_CYC = pwrseq_pkg::LOCKOUT_CYC, // Enable lockout
   parameter int unsigned RELEASE_CYC = pwrseq_pkg::RELEASE_CYC // Release debounce
) (
   input wire logic sys_clk, // 100 MHz clock
   input wire logic reset, // Synchronous, active high
   input wire logic clk_en, // Freezes all state while low
   input wire logic push_button_n, // Momentary switch, low when pressed
   input wire logic kill_n, // Power-off request from processor, active low
   input wire logic [pwrseq_pkg::EXT_W-1:0] on_time_extend, // Extra on debounce cycles
   input wire logic [pwrseq_pkg::EXT_W-1:0] off_time_extend, // Extra off debounce cycles
   output logic power_enable, // Supply enable, polarity per variant
   output logic power_enable_oe, // Open-drain enable pull-down active
   output logic shutdown_req_n, // Shutdown request level, active low
   output logic shutdown_req_oe // Open-drain request driven low
);
   // ****************************************
   // State
   // ****************************************
   typedef enum logic [3:0] {
      ST_OFF_LOCK,
      ST_OFF_RELEASE,
      ST_OFF_IDLE,
      ST_ON_DEBOUNCE,
      ST_ON_BLANK,
      ST_ON_RELEASE,
      ST_ON_IDLE,
      ST_OFF_DEBOUNCE,
      ST_OFF_DELAY
   } seq_state_t;

   typedef struct packed {
      seq_state_t fsm;
      logic enable_on;
      logic shutdown_on;
      logic pwr_out;
      logic pwr_oe;
      logic req_oe;
      logic req_n;
   } seq_regs_t;

   seq_regs_t state_reg;
   seq_regs_t state_next;

   timer_if tif ();

   interval_timer u_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .tif(tif.tmr)
   );

   localparam logic [pwrseq_pkg::CNT_W-1:0] DB_LEN = pwrseq_pkg::CNT_W'(DEBOUNCE_CYC);
   localparam logic [pwrseq_pkg::CNT_W-1:0] BLANK_LEN = pwrseq_pkg::CNT_W'(ON_BLANK_CYC);
   localparam logic [pwrseq_pkg::CNT_W-1:0] DELAY_LEN = pwrseq_pkg::CNT_W'(OFF_DELAY_CYC);
   localparam logic [pwrseq_pkg::CNT_W-1:0] LOCK_LEN = pwrseq_pkg::CNT_W'(LOCKOUT_CYC);
   localparam logic [pwrseq_pkg::CNT_W-1:0] REL_LEN = pwrseq_pkg::CNT_W'(RELEASE_CYC);

   // Enable pin level for a given logical state; open drain drives only the low level
   function automatic logic pin_level(input logic on);
      pin_level = ENABLE_ACTIVE_HIGH ? on : ~on;
   endfunction : pin_level

   logic start_c;
   logic [pwrseq_pkg::CNT_W-1:0] len_c;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_next = state_reg;
      start_c = 1'b0;
      len_c = DB_LEN;
      case (state_reg.fsm)
         ST_OFF_LOCK: begin
            if (tif.done) begin
               start_c = 1'b1;
               len_c = REL_LEN;
               state_next.fsm = ST_OFF_RELEASE;
            end
         end
         ST_OFF_RELEASE: begin
            // held press is no new press
            if (!push_button_n) begin
               start_c = 1'b1;
               len_c = REL_LEN;
            end else if (tif.done) begin
               state_next.fsm = ST_OFF_IDLE;
            end
         end
         ST_OFF_IDLE: begin
            if (!push_button_n) begin
               start_c = 1'b1;
               len_c = DB_LEN + on_time_extend;
               state_next.fsm = ST_ON_DEBOUNCE;
            end
         end
         ST_ON_DEBOUNCE: begin
            if (push_button_n) begin
               state_next.fsm = ST_OFF_IDLE;
            end else if (tif.done) begin
               state_next.enable_on = 1'b1;
               start_c = 1'b1;
               len_c = BLANK_LEN;
               state_next.fsm = ST_ON_BLANK;
            end
         end
         ST_ON_BLANK: begin
            if (tif.done) begin
               if (!kill_n) begin
                  state_next.enable_on = 1'b0;
                  start_c = 1'b1;
                  len_c = LOCK_LEN;
                  state_next.fsm = ST_OFF_LOCK;
               end else begin
                  start_c = 1'b1;
                  len_c = REL_LEN;
                  state_next.fsm = ST_ON_RELEASE;
               end
            end
         end
         ST_ON_RELEASE, ST_ON_IDLE: begin
            if (!kill_n) begin
               state_next.enable_on = 1'b0;
               start_c = 1'b1;
               len_c = LOCK_LEN;
               state_next.fsm = ST_OFF_LOCK;
            end else if (state_reg.fsm == ST_ON_RELEASE) begin
               if (!push_button_n) begin
                  start_c = 1'b1;
                  len_c = REL_LEN;
               end else if (tif.done) begin
                  state_next.fsm = ST_ON_IDLE;
               end
            end else if (!push_button_n) begin
               start_c = 1'b1;
               len_c = DB_LEN + off_time_extend;
               state_next.fsm = ST_OFF_DEBOUNCE;
            end
         end
         ST_OFF_DEBOUNCE: begin
            if (!kill_n) begin
               state_next.enable_on = 1'b0;
               start_c = 1'b1;
               len_c = LOCK_LEN;
               state_next.fsm = ST_OFF_LOCK;
            end else if (push_button_n) begin
               state_next.fsm = ST_ON_IDLE;
            end else if (tif.done) begin
               state_next.shutdown_on = 1'b1;
               start_c = 1'b1;
               len_c = DELAY_LEN;
               state_next.fsm = ST_OFF_DELAY;
            end
         end
         ST_OFF_DELAY: begin
            // kill or delay expiry ends power
            if (!kill_n || tif.done) begin
               state_next.enable_on = 1'b0;
               state_next.shutdown_on = 1'b0;
               start_c = 1'b1;
               len_c = LOCK_LEN;
               state_next.fsm = ST_OFF_LOCK;
            end
         end
         default: begin
            state_next.fsm = ST_OFF_IDLE;
            state_next.enable_on = 1'b0;
            state_next.shutdown_on = 1'b0;
         end
      endcase
      state_next.pwr_out = pin_level(state_next.enable_on);
      state_next.pwr_oe = ~state_next.pwr_out;
      state_next.req_oe = state_next.shutdown_on;
      state_next.req_n = ~state_next.shutdown_on;
   end

   assign tif.start = start_c;
   assign tif.length = len_c;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         // released enable, idle request; straight to idle, no lockout of first press
         state_reg.fsm <= ST_OFF_IDLE;
         state_reg.enable_on <= 1'b0;
         state_reg.shutdown_on <= 1'b0;
         state_reg.pwr_out <= ~ENABLE_ACTIVE_HIGH;
         state_reg.pwr_oe <= ENABLE_ACTIVE_HIGH;
         state_reg.req_oe <= 1'b0;
         state_reg.req_n <= 1'b1;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign power_enable = state_reg.pwr_out;
   assign power_enable_oe = state_reg.pwr_oe;
   assign shutdown_req_n = state_reg.req_n;
   assign shutdown_req_oe = state_reg.req_oe;
endmodule : pushbutton_power_sequencer

// file: verification/pwrseq_props.sv
/* Checker for the push button power sequencer ports.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module pwrseq_props #(
   parameter bit ENABLE_ACTIVE_HIGH = 1'b1, // Enable polarity
   parameter int unsigned OFF_DELAY_CYC = 80 // Turn-off delay
) (
   input wire logic sys_clk, // Clock
   input wire logic reset, // Sync reset
   input wire logic clk_en, // Clock enable
   input wire logic push_button_n, // Button
   input wire logic kill_n, // Power-off request
   input wire logic power_enable, // Enable
   input wire logic power_enable_oe, // Enable drive
   input wire logic shutdown_req_n, // Shutdown request
   input wire logic shutdown_req_oe // Request drive
);
   localparam int DLY_MAX = OFF_DELAY_CYC + 3;
   wire logic on = (power_enable == ENABLE_ACTIVE_HIGH);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   enable_drive_a: assert property (power_enable_oe == !power_enable)
      else $error("enable drive not inverse of enable");
   req_drive_a: assert property (shutdown_req_oe == !shutdown_req_n)
      else $error("request drive not inverse of request");
   reset_off_a: assert property (@(posedge sys_clk) disable iff (1'b0) reset |=> !on && shutdown_req_n)
      else $error("reset left enable or request active");
   on_press_a: assert property ($rose(on) |-> !$past(push_button_n))
      else $error("enable rose without a held press");
   blank_hold_a: assert property ($rose(on) |=> on [*8])
      else $error("enable dropped inside blanking");
   off_press_a: assert property ($fell(shutdown_req_n) |-> on && !$past(push_button_n))
      else $error("request fell without a held press");
   delay_bound_a: assert property ($fell(shutdown_req_n) |-> ##[1:DLY_MAX] !on)
      else $error("enable outlived turn-off delay");
   kill_delay_a: assert property (!shutdown_req_n && !kill_n && clk_en |-> ##[1:2] !on)
      else $error("kill during delay did not release");
   req_idle_a: assert property (!on && !$past(on) |-> shutdown_req_n)
      else $error("request active while powered off");
   lockout_a: assert property ($fell(on) |=> !on [*8])
      else $error("enable returned inside lockout");
   cover property ($rose(on));
   cover property ($fell(shutdown_req_n));
   cover property ($fell(on) && kill_n);
endmodule : pwrseq_props
bind pushbutton_power_sequencer pwrseq_props #(.ENABLE_ACTIVE_HIGH(ENABLE_ACTIVE_HIGH),
   .OFF_DELAY_CYC(OFF_DELAY_CYC)) i_pwrseq_props (.sys_clk(sys_clk), .reset(reset),
   .clk_en(clk_en), .push_button_n(push_button_n), .kill_n(kill_n),
   .power_enable(power_enable), .power_enable_oe(power_enable_oe),
   .shutdown_req_n(shutdown_req_n), .shutdown_req_oe(shutdown_req_oe));

// file: verification/proc_model.sv
/* Processor side of the handshake: raises kill after boot, drops it on request.
   Assumes powered is the logical enable level. */
`timescale 1ns/1ps
module proc_model #(
   parameter int BOOT_CYC = 5, // Boot time
   parameter int ACK_CYC = 6 // Housekeeping time
) (
   input wire logic sys_clk, // Clock
   input wire logic powered, // Enable on
   input wire logic shutdown_req_n, // Request from sequencer
   input wire logic boot_ok, // Boot succeeds
   input wire logic ack_req, // Answer a request
   input wire logic force_kill, // Switch off in normal operation
   output logic kill_n // Power-off request
);
   int up_cnt = 0;
   int req_cnt = 0;
   always @(posedge sys_clk) begin
      up_cnt <= powered ? up_cnt + 1 : 0;
      req_cnt <= !shutdown_req_n ? req_cnt + 1 : 0;
   end
   // kill handshake; an unpowered processor holds kill low
   assign kill_n = powered && boot_ok && up_cnt >= BOOT_CYC && !force_kill
      && !(ack_req && req_cnt >= ACK_CYC);
endmodule : proc_model

// file: verification/tb_pushbutton_power_sequencer.sv
/* Self-checking bench for the power sequencer with a processor model.
   Assumes shortened timer parameters and the high-true enable variant. */
`timescale 1ns/1ps
module tb_pushbutton_power_sequencer;
   localparam int DB = 10;
   localparam int BL = 40;
   localparam int OD = 80;
   localparam int LO = 20;
   localparam int RL = 10;
   logic sys_clk = 0, reset = 1, clk_en = 1, push_button_n = 1;
   logic boot_ok = 1, ack_req = 0, force_kill = 0;
   logic [31:0] on_time_extend = 0, off_time_extend = 0;
   logic power_enable, power_enable_oe, shutdown_req_n, shutdown_req_oe, kill_n;
   logic en_low;
   int fail_count = 0, check_count = 0, n;
   wire logic on = (power_enable === 1'h1);
   pushbutton_power_sequencer #(.DEBOUNCE_CYC(DB), .ON_BLANK_CYC(BL), .OFF_DELAY_CYC(OD),
      .LOCKOUT_CYC(LO), .RELEASE_CYC(RL)) i_pushbutton_power_sequencer (.sys_clk(sys_clk),
      .reset(reset), .clk_en(clk_en), .push_button_n(push_button_n), .kill_n(kill_n),
      .on_time_extend(on_time_extend), .off_time_extend(off_time_extend),
      .power_enable(power_enable), .power_enable_oe(power_enable_oe),
      .shutdown_req_n(shutdown_req_n), .shutdown_req_oe(shutdown_req_oe));
   // Low-true variant on the same inputs; its enable must mirror the first one
   pushbutton_power_sequencer #(.ENABLE_ACTIVE_HIGH(1'b0), .DEBOUNCE_CYC(DB),
      .ON_BLANK_CYC(BL), .OFF_DELAY_CYC(OD), .LOCKOUT_CYC(LO), .RELEASE_CYC(RL))
      i_pushbutton_power_sequencer_low (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .push_button_n(push_button_n), .kill_n(kill_n), .on_time_extend(on_time_extend),
      .off_time_extend(off_time_extend), .power_enable(en_low), .power_enable_oe(),
      .shutdown_req_n(), .shutdown_req_oe());
   proc_model i_proc_model (.sys_clk(sys_clk), .powered(on), .shutdown_req_n(shutdown_req_n),
      .boot_ok(boot_ok), .ack_req(ack_req), .force_kill(force_kill), .kill_n(kill_n));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic near(input int got, input int exp);
      check(32'(got >= exp - 3 && got <= exp + 3), 32'h1);
   endtask : near
   task automatic tick(input int cyc);
      repeat (cyc) @(posedge sys_clk);
      #1;
   endtask : tick
   // Bounded wait for the enable (sel 0) or the request (sel 1) to reach val
   task automatic wait_sig(input bit sel, input logic val, input int max, output int cnt);
      cnt = 0;
      while ((sel ? shutdown_req_n : on) !== val) begin
         if (cnt == max) begin
            fail_count++;
            print_verdict();
         end
         tick(1);
         cnt++;
      end
   endtask : wait_sig
   task automatic t_bounce();
      repeat (3) begin
         push_button_n = 0;
         tick(DB - 2);
         push_button_n = 1;
         tick(1);
      end
      check(power_enable, 1'h0);
      clk_en = 0;
      push_button_n = 0;
      tick(DB + 10);
      check(power_enable, 1'h0);
      push_button_n = 1;
      clk_en = 1;
      tick(2);
      $display("bounce test done");
   endtask : t_bounce
   task automatic t_on(input int ext);
      on_time_extend = ext;
      push_button_n = 0;
      wait_sig(0, 1'h1, 300, n);
      near(n, DB + ext + 2);
      check(power_enable_oe, 1'h0);
      check(en_low, 1'h0);
      push_button_n = 1;
      tick(BL + RL + 5);
      $display("on test done");
   endtask : t_on
   task automatic t_off(input int ext, input logic ack, input int rel);
      off_time_extend = ext;
      ack_req = ack;
      push_button_n = 0;
      wait_sig(1, 1'h0, 300, n);
      near(n, DB + ext + 2);
      check(shutdown_req_oe, 1'h1);
      push_button_n = 1;
      wait_sig(0, 1'h0, OD + 10, n);
      near(n, rel);
      // A press held through the lockout must not count as a new press
      push_button_n = 0;
      tick(LO - 2);
      check(power_enable, 1'h0);
      tick(RL + 12);
      check(power_enable, 1'h0);
      push_button_n = 1;
      tick(RL + 3);
      push_button_n = 0;
      wait_sig(0, 1'h1, 300, n);
      near(n, DB + int'(on_time_extend) + 2);
      push_button_n = 1;
      tick(BL + RL + 5);
      $display("off test done");
   endtask : t_off
   task automatic t_kill_abort();
      force_kill = 1;
      wait_sig(0, 1'h0, 3, n);
      check(32'(n <= 2), 32'h1);
      force_kill = 0;
      boot_ok = 0;
      tick(LO + RL + 5);
      push_button_n = 0;
      wait_sig(0, 1'h1, 300, n);
      push_button_n = 1;
      wait_sig(0, 1'h0, BL + 10, n);
      near(n, BL);
      $display("kill and abort test done");
   endtask : t_kill_abort
   initial begin
      tick(2);
      reset = 0;
      check(power_enable, 1'h0);
      check(shutdown_req_n, 1'h1);
      check(power_enable_oe, 1'h1);
      check(en_low, 1'h1);
      check(shutdown_req_oe, 1'h0);
      t_bounce();
      t_on(5);
      t_off(7, 1'h0, OD + 1);
      t_off(0, 1'h1, 8);
      t_kill_abort();
      print_verdict();
   end
endmodule : tb_pushbutton_power_sequencer
